// *** rtl/ssel_top.sv ***
/*
 Slave front end of a two-wire serial memory: select byte decode, two address
 bytes, acknowledge duties, write inhibit, write cycle and standby.
 Assumes scl and sda_i come straight from the pins, sda is pulled up outside,
 and reset_n is the power-on reset.
*/
`timescale 1ns/1ps

module ssel_top import ssel_pkg::*; #(
    parameter int unsigned WRITE_CYCLES = `SSEL_TW_CYCLES,   // Write cycle in clocks
    parameter logic [3:0] DEVICE_TYPE = `SSEL_TYPE_ID_DEF     // Arbitrary value
)(
    input wire logic clock,                  // Core clock, 250 MHz
    input wire logic reset_n,                // Power-on reset, active low
    input wire logic scl,                    // Serial clock from the master
    input wire logic sda_i,                  // Serial data pin level
    output logic sda_o,                      // Serial data drive value
    output logic sda_oe,                     // Serial data pull-down enable
    input wire logic chip_select_low_pin,    // Chip select, matches b2
    input wire logic chip_select_high_pin,   // Chip select, matches b3
    input wire logic write_inhibit_pin,      // High blocks array writes
    output logic standby,                    // Idle, waiting for Start
    output logic write_busy                  // Self-timed write cycle running
);

    localparam logic [`SSEL_PROG_W-1:0] PROG_LAST = (`SSEL_PROG_W)'(WRITE_CYCLES - 1);

    if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << `SSEL_PROG_W)) begin : g_bad_tw
        $error("ssel_top: write cycle count outside counter range");
    end

    function automatic logic sel_match(
        input logic [7:0] sel,
        input logic cs_hi,
        input logic cs_lo,
        input logic [3:0] dtype
    );
        sel_match = (sel[`SSEL_SEL_TYPE_HI:`SSEL_SEL_TYPE_LO] == dtype) &&
                    (sel[`SSEL_SEL_CS_HI] == cs_hi) &&
                    (sel[`SSEL_SEL_CS_LO] == cs_lo);
    endfunction

    ssel_mem_if #(.AW(`SSEL_ADDR_W), .DW(`SSEL_DATA_W)) mif ();

    ssel_mem #(
        .DEPTH(`SSEL_MEM_DEPTH),
        .AW(`SSEL_ADDR_W),
        .DW(`SSEL_DATA_W)
    ) u_mem (
        .clock(clock),
        .port(mif)
    );

    // Link domain: bits are taken on the master's rising clock edge
    ssel_link_t l_q;
    ssel_link_t l_d;

    always_comb begin
        l_d = l_q;
        l_d.shift = {l_q.shift[6:0], sda_i};
    end

    always_ff @(posedge scl or negedge reset_n) begin
        if (!reset_n) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    // Core domain
    ssel_core_t q;
    ssel_core_t d;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic cs_lo_s;
    logic cs_hi_s;
    logic wi_s;
    logic [7:0] rx;
    logic prog_go;

    assign scl_s = q.scl_sy[1];
    assign sda_s = q.sda_sy[1];
    assign cs_lo_s = q.csl_sy[1];
    assign cs_hi_s = q.csh_sy[1];
    assign wi_s = q.wi_sy[1];
    assign scl_rise = scl_s & ~q.scl_prev;
    assign scl_fall = ~scl_s & q.scl_prev;
    assign start_ev = scl_s & q.scl_prev & q.sda_prev & ~sda_s;
    assign stop_ev = scl_s & q.scl_prev & ~q.sda_prev & sda_s;
    // The shift word is read a few clocks after the rising edge that completed
    // it and stays still until the next rising edge, a half period away at least
    assign rx = l_q.shift;
    assign prog_go = stop_ev && q.state == ST_WDAT && q.pend && q.cnt == `SSEL_AFTER_ACK;

    always_comb begin
        d = q;
        d.scl_sy = {q.scl_sy[0], scl};
        d.sda_sy = {q.sda_sy[0], sda_i};
        d.csl_sy = {q.csl_sy[0], chip_select_low_pin};
        d.csh_sy = {q.csh_sy[0], chip_select_high_pin};
        d.wi_sy = {q.wi_sy[0], write_inhibit_pin};
        d.scl_prev = scl_s;
        d.sda_prev = sda_s;
        mif.re = 1'b0;
        mif.we = 1'b0;
        mif.addr = q.addr;
        mif.wdata = q.pend_data;

        if (q.state == ST_PROG) begin
            // Bus is not even watched for Start here
            if (q.prog_cnt == PROG_LAST) begin
                d.state = ST_IDLE;
                d.prog_cnt = '0;
            end else begin
                d.prog_cnt = q.prog_cnt + 24'h000001;
            end
        end else if (start_ev) begin
            d.state = ST_SEL;
            d.cnt = '0;
            d.after9 = 1'b0;
            d.ack_pend = 1'b0;
            d.ack_oe = 1'b0;
            d.tx_on = 1'b0;
            d.pend = 1'b0;
            d.inh = wi_s;
        end else if (stop_ev) begin
            d.cnt = '0;
            d.after9 = 1'b0;
            d.ack_pend = 1'b0;
            d.ack_oe = 1'b0;
            d.tx_on = 1'b0;
            d.pend = 1'b0;
            if (prog_go) begin
                mif.we = 1'b1;
                mif.addr = q.pend_addr;
                d.state = ST_PROG;
            end else begin
                d.state = ST_IDLE;
            end
        end else begin
            // Inhibit counts from Start until the end of the address bytes
            if (q.state == ST_SEL || q.state == ST_AHI || q.state == ST_ALO) begin
                d.inh = q.inh | wi_s;
            end
            if (scl_rise && q.state != ST_IDLE) begin
                if (q.cnt == `SSEL_ACK_SLOT) begin
                    d.cnt = '0;
                    d.after9 = 1'b1;
                    // Our own select acknowledge holds the line low; not a master ack
                    if (q.state == ST_RDAT && !q.ack_oe && sda_s) begin
                        d.state = ST_IDLE;
                    end else if (q.state == ST_RDAT && !q.ack_oe) begin
                        d.addr = q.addr + 17'h00001;
                        mif.re = 1'b1;
                        mif.addr = q.addr + 17'h00001;
                    end
                end else begin
                    d.cnt = q.cnt + 4'h1;
                    if (q.cnt == `SSEL_LAST_BIT) begin
                        case (q.state)
                            ST_SEL: begin
                                if (sel_match(rx, cs_hi_s, cs_lo_s, DEVICE_TYPE)) begin
                                    d.ack_pend = 1'b1;
                                    if (rx[`SSEL_SEL_RW]) begin
                                        d.state = ST_RDAT;
                                        mif.re = 1'b1;
                                    end else begin
                                        d.state = ST_AHI;
                                        d.addr[16] = rx[`SSEL_SEL_TOP];
                                    end
                                end else begin
                                    d.state = ST_IDLE;
                                end
                            end
                            ST_AHI: begin
                                d.addr[15:8] = rx;
                                d.ack_pend = 1'b1;
                                d.state = ST_ALO;
                            end
                            ST_ALO: begin
                                d.addr[7:0] = rx;
                                d.ack_pend = 1'b1;
                                d.state = ST_WDAT;
                            end
                            ST_WDAT: begin
                                if (!q.inh) begin
                                    d.ack_pend = 1'b1;
                                    // Only the last byte waits for Stop; earlier
                                    // bytes of a page are written as the next arrives
                                    if (q.pend) begin
                                        mif.we = 1'b1;
                                        mif.addr = q.pend_addr;
                                    end
                                    d.pend = 1'b1;
                                    d.pend_data = rx;
                                    d.pend_addr = q.addr;
                                    d.addr = {q.addr[16:8], q.addr[7:0] + 8'h01};
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            if (scl_fall) begin
                if (q.cnt == `SSEL_ACK_SLOT && q.ack_pend) begin
                    d.ack_oe = 1'b1;
                    d.ack_pend = 1'b0;
                end
                if (q.cnt == `SSEL_ACK_SLOT && q.tx_on) begin
                    d.tx_on = 1'b0;
                end
                if (q.after9) begin
                    d.after9 = 1'b0;
                    d.ack_oe = 1'b0;
                    if (q.state == ST_RDAT) begin
                        d.tx_on = 1'b1;
                        d.tx_byte = mif.rdata;
                    end
                end else if (q.tx_on && q.cnt != 4'h0 && q.cnt != `SSEL_ACK_SLOT) begin
                    d.tx_byte = {q.tx_byte[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Open drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe = q.ack_oe | (q.tx_on & ~q.tx_byte[7]);
    assign standby = (q.state == ST_IDLE);
    assign write_busy = (q.state == ST_PROG);

    a_ack_slot: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(q.ack_oe) |-> (q.cnt == 4'h8 && !scl_s))
        else $error("acknowledge driven outside the ninth slot");

    a_type_mismatch: assert property (@(posedge clock) disable iff (!reset_n)
        (scl_rise && q.state == ST_SEL && q.cnt == 4'h7 && rx[7:4] != DEVICE_TYPE)
        |=> (q.state == ST_IDLE && !q.ack_pend) ##1 !q.ack_oe)
        else $error("wrong type code was not refused");

    a_cs_mismatch: assert property (@(posedge clock) disable iff (!reset_n)
        (scl_rise && q.state == ST_SEL && q.cnt == 4'h7 &&
         rx[3:2] != {cs_hi_s, cs_lo_s}) |=> q.state == ST_IDLE)
        else $error("chip select mismatch was not refused");

    a_sel_accept: assert property (@(posedge clock) disable iff (!reset_n)
        (scl_rise && q.state == ST_SEL && q.cnt == 4'h7 &&
         sel_match(rx, cs_hi_s, cs_lo_s, DEVICE_TYPE))
        |=> q.ack_pend && (q.state == (rx[0] ? ST_RDAT : ST_AHI)))
        else $error("matching select byte not accepted");

    a_inhibit_nowrite: assert property (@(posedge clock) disable iff (!reset_n)
        (q.inh && q.state == ST_WDAT) |-> !mif.we)
        else $error("array written while inhibited");

    a_data_nack: assert property (@(posedge clock) disable iff (!reset_n)
        (scl_rise && q.state == ST_WDAT && q.cnt == 4'h7 && q.inh)
        |=> !q.ack_pend && q.cnt == 4'h8)
        else $error("inhibited data byte acknowledged");

    a_prog_start: assert property (@(posedge clock) disable iff (!reset_n)
        prog_go |-> mif.we ##1 (write_busy && q.prog_cnt == '0))
        else $error("stop after ack did not start the write cycle");

    a_prog_quiet: assert property (@(posedge clock) disable iff (!reset_n)
        (write_busy && start_ev) |=> (q.state != ST_SEL && !sda_oe))
        else $error("bus answered during the write cycle");

    a_stop_standby: assert property (@(posedge clock) disable iff (!reset_n)
        (stop_ev && !write_busy && !prog_go) |=> (standby && !sda_oe))
        else $error("stop did not return to standby");

    a_write_nodrive: assert property (@(posedge clock) disable iff (!reset_n)
        ((q.state == ST_AHI || q.state == ST_ALO || q.state == ST_WDAT) &&
         q.cnt != 4'h0 && q.cnt != 4'h8 && !q.after9) |-> !sda_oe)
        else $error("data line driven while master transmits");

endmodule

// *** common/ssel_map.svh ***
/*
 Constants of the serial memory select front end: array shape, select byte
 fields, bit slots and the self-timed write cycle.
 Assumes it is included once per compilation unit before ssel_pkg.
*/
`ifndef SSEL_MAP_SVH
`define SSEL_MAP_SVH

`define SSEL_MEM_DEPTH 131072
`define SSEL_ADDR_W 17
`define SSEL_DATA_W 8

// Select byte field positions
`define SSEL_SEL_TYPE_HI 7
`define SSEL_SEL_TYPE_LO 4
`define SSEL_SEL_CS_HI 3
`define SSEL_SEL_CS_LO 2
`define SSEL_SEL_TOP 1
`define SSEL_SEL_RW 0

// Arbitrary value, stands in for the built-in device type code
`define SSEL_TYPE_ID_DEF 4'hC

// Bit counter values: last data bit, acknowledge slot and the first slot after it
`define SSEL_LAST_BIT 4'h7
`define SSEL_ACK_SLOT 4'h8
`define SSEL_AFTER_ACK 4'h1

// Self-timed write cycle
`define SSEL_TW_MS 5
`define SSEL_CLK_MHZ 250
`define SSEL_TW_CYCLES (`SSEL_TW_MS * `SSEL_CLK_MHZ * 1000)
`define SSEL_PROG_W 24

`endif

// *** common/ssel_pkg.sv ***
/*
 Types of the serial memory select front end: state encoding and the state
 records of the link and core domains.
 Assumes ssel_map.svh is reachable on the include path.
*/
`include "ssel_map.svh"

package ssel_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SEL = 3'b001,
        ST_AHI = 3'b010,
        ST_ALO = 3'b011,
        ST_WDAT = 3'b100,
        ST_RDAT = 3'b101,
        ST_PROG = 3'b110
    } ssel_state_t;

    typedef struct packed {
        logic [7:0] shift;
    } ssel_link_t;

    typedef struct packed {
        logic [1:0] scl_sy;
        logic [1:0] sda_sy;
        logic [1:0] csl_sy;
        logic [1:0] csh_sy;
        logic [1:0] wi_sy;
        logic scl_prev;
        logic sda_prev;
        ssel_state_t state;
        logic [3:0] cnt;
        logic after9;
        logic ack_pend;
        logic ack_oe;
        logic tx_on;
        logic [7:0] tx_byte;
        logic inh;
        logic [`SSEL_ADDR_W-1:0] addr;
        logic pend;
        logic [`SSEL_DATA_W-1:0] pend_data;
        logic [`SSEL_ADDR_W-1:0] pend_addr;
        logic [`SSEL_PROG_W-1:0] prog_cnt;
    } ssel_core_t;

endpackage

// *** common/ssel_mem_if.sv ***
/*
 Port bundle between the select front end and its memory array.
 Assumes one controller and one array on the same clock.
*/
`timescale 1ns/1ps

interface ssel_mem_if #(
    parameter int AW = 17,
    parameter int DW = 8
);
    logic re;
    logic we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;

    modport ctrl (output re, output we, output addr, output wdata, input rdata);
    modport mem (input re, input we, input addr, input wdata, output rdata);
endinterface

// *** rtl/ssel_mem.sv ***
/*
 Byte-wide array with registered read data that holds until the next read.
 Assumes the controller never reads and writes in the same cycle.
*/
`timescale 1ns/1ps

module ssel_mem #(
    parameter int DEPTH = 131072,
    parameter int AW = 17,
    parameter int DW = 8
)(
    input wire logic clock,   // Core clock
    ssel_mem_if.mem port      // Array access
);
    logic [DW-1:0] cells [DEPTH];

    if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
        $error("ssel_mem: depth does not fit the address width");
    end

    // No reset on the array: contents survive a power-on reset
    always_ff @(posedge clock) begin
        if (port.we) begin
            cells[port.addr] <= port.wdata;
        end
        if (port.re) begin
            port.rdata <= cells[port.addr];
        end
    end
endmodule

// *** verification/ssel_host.sv ***
/*
 Behavioural two-wire bus master that drives the serial memory front end.
 Assumes the bench resolves the data line with a pull-up from both enables.
*/
`timescale 1ns/1ps

module ssel_host (
    output logic scl,        // Serial clock, stands high between frames
    output logic sda_oe,     // High while the master pulls data low
    input wire logic sda     // Resolved data line level
);
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end

    // Data moves only while the clock is low, well clear of either edge
    task automatic slot(input logic b, output logic s);
        sda_oe = !b;
        #24 scl = 1'b1;
        #16 s = sda;
        #16 scl = 1'b0;
        #8;
    endtask

    // Also serves as a repeated start when the clock is low
    task automatic start();
        if (!scl) begin
            sda_oe = 1'b0;
            #24 scl = 1'b1;
            #24;
        end
        sda_oe = 1'b1;
        #24 scl = 1'b0;
        #8;
    endtask

    // One more clock after the acknowledge slot, then data rises
    task automatic stop();
        sda_oe = 1'b1;
        #24 scl = 1'b1;
        #24 sda_oe = 1'b0;
        #24;
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(b[i], s);
        end
        slot(1'b1, s);
        ack = !s;
    endtask

    task automatic recv(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(1'b1, s);
            d[i] = s;
        end
        slot(!mack, s);
    endtask
endmodule

// *** verification/ssel_test.sv ***
/*
 Self-checking bench for the serial memory select front end.
 Assumes ssel_top and ssel_host are compiled before it.
*/
`timescale 1ns/1ps

module ssel_test;
    localparam logic [3:0] DEV_TYPE = 4'hC; // Arbitrary value
    localparam int unsigned WR_CYC = 300;
    localparam int LIMIT = 40000;

    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic cs_lo = 1'b0;
    logic cs_hi = 1'b0;
    logic wi = 1'b0;
    logic mst_scl, mst_oe, dut_oe, standby, write_busy, ack;
    logic [7:0] rd;
    wire logic sda_line = !(mst_oe || dut_oe);
    int fails = 0;
    int checked = 0;
    int cycles = 0;

    always #2 clock = ~clock;

    ssel_top #(.WRITE_CYCLES(WR_CYC), .DEVICE_TYPE(DEV_TYPE)) u_ssel_top (
        .clock(clock),
        .reset_n(reset_n),
        .scl(mst_scl),
        .sda_i(sda_line),
        .sda_o(),
        .sda_oe(dut_oe),
        .chip_select_low_pin(cs_lo),
        .chip_select_high_pin(cs_hi),
        .write_inhibit_pin(wi),
        .standby(standby),
        .write_busy(write_busy)
    );

    ssel_host u_ssel_host (.scl(mst_scl), .sda_oe(mst_oe), .sda(sda_line));

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check_bit(input logic got, input logic exp, input string msg);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %b expected %b", $time, msg, got, exp);
        end
    endtask

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    function automatic logic [7:0] sel(input logic [1:0] cs, input logic top, input logic rw);
        return {DEV_TYPE, cs, top, rw};
    endfunction

    task automatic address(input logic [16:0] a);
        u_ssel_host.start();
        u_ssel_host.send(sel({cs_hi, cs_lo}, a[16], 1'b0), ack);
        check_bit(ack, 1'b1, "select ack");
        u_ssel_host.send(a[15:8], ack);
        check_bit(ack, 1'b1, "high address ack");
        u_ssel_host.send(a[7:0], ack);
        check_bit(ack, 1'b1, "low address ack");
    endtask

    task automatic write2(input logic [16:0] a, input logic [7:0] d0, input logic [7:0] d1,
                          input int n);
        address(a);
        u_ssel_host.send(d0, ack);
        check_bit(ack, !wi, "data ack");
        if (n > 1) begin
            u_ssel_host.send(d1, ack);
            check_bit(ack, !wi, "second data ack");
        end
        u_ssel_host.stop();
        repeat (6) @(negedge clock);
        check_bit(write_busy, !wi, "write cycle start");
        check_bit(standby, wi, "standby after stop");
        if (!wi) begin
            // Select sent while the write cycle runs must be ignored
            u_ssel_host.start();
            u_ssel_host.send(sel({cs_hi, cs_lo}, 1'b0, 1'b0), ack);
            check_bit(ack, 1'b0, "select during write cycle");
            check_bit(write_busy, 1'b1, "write cycle still running");
            u_ssel_host.stop();
            for (int i = 0; i < 2 * WR_CYC && write_busy !== 1'b0; i++) @(negedge clock);
            check_bit(write_busy, 1'b0, "write cycle end");
            check_bit(standby, 1'b1, "standby after write");
        end
    endtask

    task automatic read_at(input logic [16:0] a, input logic [7:0] exp);
        address(a);
        u_ssel_host.start();
        u_ssel_host.send(sel({cs_hi, cs_lo}, 1'b0, 1'b1), ack);
        check_bit(ack, 1'b1, "read select ack");
        u_ssel_host.recv(1'b0, rd);
        check_byte(rd, exp, "read data");
        u_ssel_host.stop();
        repeat (4) @(negedge clock);
        check_bit(standby, 1'b1, "standby after read");
    endtask

    task automatic probe(input logic [7:0] s, input logic exp);
        u_ssel_host.start();
        u_ssel_host.send(s, ack);
        check_bit(ack, exp, "select match");
        if (ack === 1'b1) begin
            u_ssel_host.recv(1'b0, rd);
        end
        u_ssel_host.stop();
        repeat (4) @(negedge clock);
        check_bit(standby, 1'b1, "standby after probe");
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails = fails + 1;
            end_of_test();
        end
    end

    initial begin
        repeat (6) @(negedge clock);
        check_bit(standby, 1'b1, "standby in reset");
        check_bit(dut_oe, 1'b0, "bus released in reset");
        reset_n = 1'b1;
        cs_hi = 1'b1;
        repeat (4) @(negedge clock);
        check_bit(standby, 1'b1, "standby after reset");
        check_bit(write_busy, 1'b0, "idle after reset");
        write2(17'h1_1234, 8'hA5, 8'h00, 1);
        write2(17'h0_1234, 8'h5A, 8'h00, 1);
        read_at(17'h1_1234, 8'hA5);
        read_at(17'h0_1234, 8'h5A);
        // Page write that wraps within the row
        write2(17'h0_12FF, 8'h3C, 8'hC3, 2);
        read_at(17'h0_12FF, 8'h3C);
        read_at(17'h0_1200, 8'hC3);
        wi = 1'b1;
        write2(17'h1_1234, 8'hFF, 8'h00, 2);
        wi = 1'b0;
        read_at(17'h1_1234, 8'hA5);
        // Pins at zero stand for floating pins; index 4 carries a wrong type code
        for (int p = 0; p < 4; p++) begin
            {cs_hi, cs_lo} = p[1:0];
            for (int c = 0; c < 5; c++) begin
                probe(c < 4 ? sel(c[1:0], 1'b0, 1'b1) : {~DEV_TYPE, p[1:0], 2'b01}, c == p);
            end
        end
        cs_hi = 1'b1;
        cs_lo = 1'b0;
        u_ssel_host.start();
        u_ssel_host.send(sel(2'b10, 1'b0, 1'b0), ack);
        check_bit(ack, 1'b1, "select before reset");
        @(negedge clock);
        reset_n = 1'b0;
        @(negedge clock);
        check_bit(standby, 1'b1, "standby once reset returns");
        u_ssel_host.send(8'h12, ack);
        check_bit(ack, 1'b0, "address under reset");
        u_ssel_host.start();
        u_ssel_host.send(sel(2'b10, 1'b0, 1'b0), ack);
        check_bit(ack, 1'b0, "select under reset");
        u_ssel_host.stop();
        @(negedge clock);
        reset_n = 1'b1;
        repeat (4) @(negedge clock);
        read_at(17'h0_1200, 8'hC3);
        end_of_test();
    end
endmodule
